// *** smma_params.svh ***
// constants for the switch matrix memory access block
`ifndef SMMA_PARAMS_SVH
`define SMMA_PARAMS_SVH
// register offsets (byte addresses, 16-bit registers)
`define SMMA_OFF_CONN_MEM_DATA_REG 8'h0E
`define SMMA_OFF_CONN_MEM_ADDRESS_REG 8'h10
`define SMMA_OFF_SFC 8'h12
`define SMMA_OFF_IRQ_STAT 8'h20
`define SMMA_OFF_IRQ_MASK 8'h22
// reset values
`define SMMA_CONN_MEM_ADDRESS_REG_RST 16'h0800
`define SMMA_CONN_MEM_DATA_REG_RST 16'h0000
`define SMMA_SFC_RST 16'h0000
`define SMMA_SFC_MAX 16'hFFFF
// destination byte and access mode fields after reset (together 0800)
`define SMMA_DST_RST 8'h00
`define SMMA_MODE_RST 5'h04
// access mode byte field positions (within the upper byte)
`define SMMA_AM_READ 0
`define SMMA_AM_SEL 1
`define SMMA_AM_FULL 3
`define SMMA_AM_LIM 4
`define SMMA_AM_IDC 5
// last slot in a multiplex and last location overall
`define SMMA_LAST_SLOT 5'h1F
`define SMMA_LAST_LOC 8'hFF
// interrupt status bits
`define SMMA_IRQ_DONE 0
`define SMMA_IRQ_SAT 1
`define SMMA_IRQ_W 2
`endif

// *** smma_pkg.sv ***
// types for the switch matrix memory access block
package smma_pkg;
	typedef enum logic [1:0] {
		SMMA_IDLE,
		SMMA_CYC_WR,
		SMMA_CYC_RD
	} smma_state_e;
	typedef struct packed {
		logic idc;
		logic lim;
		logic full;
		logic sel;
		logic rd;
	} smma_mode_s;
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [15:0] data;
	} smma_cm_wr_s;
	typedef struct packed {
		smma_state_e st;
		logic [7:0] dst;
		smma_mode_s mode;
		logic [15:0] conn_mem_data_reg;
		logic [15:0] sfc;
		logic [15:0] rdata;
		logic [1:0] stat;
		logic [1:0] mask;
		logic rd_pend;
		logic dm_pend;
		logic [7:0] last;
		smma_cm_wr_s cmw;
	} smma_state_s;
endpackage

// *** smma_core.sv ***
// processor access to the connection and data memories of the switch matrix
//
// Summary of operation
// - destination write starts a memory access
// - destination: five slot bits, three multiplex bits
// - cyclic modes: destination shows current address
// - data memory: destination addresses input, read-only
// - read bit chooses read versus write
// - data memory write requests are ignored
// - full cyclic write fills through location FF
// - full cyclic read reloads after each read
// - limited cyclic write fills to slot 31
// - limited cyclic read reloads to last slot
// - identity connect maps slot to same slot
// - identity connect with cyclic: from the start through slot 31 or FF
// - fault counter read-only, clears on read
// - count errors only when enabled and locked
// - fault counter saturates at all ones
// - data memory read returns in source byte
`timescale 1ns/1ps
`include "smma_params.svh"
module smma_core import smma_pkg::*; (
	input wire logic clk_sys_i, // system clock, 250 MHz
	input wire logic srst_i, // synchronous reset, active high
	input wire logic [7:0] addr_i, // register byte address
	input wire logic [15:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [15:0] rdata_o, // read data, cycle after rd_i
	output logic [7:0] cm_addr_o, // connection memory address
	output logic [15:0] cm_wdata_o, // connection memory write data
	output logic cm_we_o, // connection memory write pulse
	input wire logic [15:0] cm_rdata_i, // connection memory data, same cycle
	output logic [7:0] dm_addr_o, // data memory address
	input wire logic [7:0] dm_rdata_i, // data memory byte, same cycle
	input wire logic prs_err_i, // analyser sequence error pulse
	input wire logic prs_en_i, // analyser enabled
	input wire logic prs_lock_i, // analyser locked to sequence
	output logic irq_o // level interrupt
);
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	// 0x0E data register: upper byte control, lower byte source
	// 0x10 address register: upper byte access mode, lower byte destination
	//   mode bit 8 read, bit 9 memory select, bit 11 full cyclic,
	//   bit 12 limited cyclic, bit 13 identity connect
	// 0x12 fault counter: read-only, cleared by its own read
	// 0x20 interrupt status: sticky, write one to clear
	// 0x22 interrupt mask: same layout as the status
	// unmapped reads return zero and unmapped writes are dropped
	//
	// the mode byte and destination byte share one word here, so a
	// single write carries both and launches the access at once;
	// software that splits them must still send destination first
	//
	// the memories themselves sit outside: connection and data memory
	// reads are combinational, so a load completes one edge later
	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// register hit test, used for reads and writes alike
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction
	// last location of a cyclic run from its mode and start
	function automatic logic [7:0] last_loc(input logic lim, input logic [7:0] start);
		if (lim) begin
			last_loc = {start[7:5], `SMMA_LAST_SLOT};
		end else begin
			last_loc = `SMMA_LAST_LOC;
		end
	endfunction

	smma_state_s s_reg; // all state
	smma_state_s s_next; // next state
	smma_mode_s m_w; // incoming mode byte
	logic [15:0] wr_word; // word written to connection memory
	logic [7:0] cur; // current connection memory address

	assign m_w = '{idc: wdata_i[8 + `SMMA_AM_IDC], lim: wdata_i[8 + `SMMA_AM_LIM],
		full: wdata_i[8 + `SMMA_AM_FULL], sel: wdata_i[8 + `SMMA_AM_SEL],
		rd: wdata_i[8 + `SMMA_AM_READ]};
	assign cur = s_reg.dst;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.cmw.we = 1'b0; // write pulse lasts one cycle
		s_next.rdata = 16'h0000; // read data only after a read
		wr_word = s_reg.conn_mem_data_reg;
		// identity connect: source byte mirrors destination
		if (s_reg.mode.idc) begin
			wr_word = {s_reg.conn_mem_data_reg[15:8], cur};
		end
		// register writes; the mode byte and the destination arrive in one word
		if (wr_i) begin
			if (hit(addr_i, `SMMA_OFF_CONN_MEM_DATA_REG)) begin
				s_next.conn_mem_data_reg = wdata_i;
			end else if (hit(addr_i, `SMMA_OFF_CONN_MEM_ADDRESS_REG)) begin
				// one write carries destination and mode, so both go in here
				s_next.dst = wdata_i[7:0];
				s_next.mode = m_w;
				s_next.st = SMMA_IDLE;
				// a write of this register launches the access
				if (!m_w.sel) begin
					if (m_w.rd) begin
						s_next.dm_pend = 1'b1;
					end
					// write to data memory is dropped on purpose
				end else if (!m_w.rd) begin
					if (m_w.full || m_w.lim) begin
						s_next.st = SMMA_CYC_WR;
						s_next.last = last_loc(m_w.lim, wdata_i[7:0]);
					end else begin
						s_next.cmw.we = 1'b1;
						s_next.cmw.addr = wdata_i[7:0];
						s_next.cmw.data = m_w.idc ?
							{s_reg.conn_mem_data_reg[15:8], wdata_i[7:0]} : s_reg.conn_mem_data_reg;
					end
				end else begin
					s_next.rd_pend = 1'b1;
					if (m_w.full || m_w.lim) begin
						s_next.st = SMMA_CYC_RD;
						s_next.last = last_loc(m_w.lim, wdata_i[7:0]);
					end
				end
			end else if (hit(addr_i, `SMMA_OFF_IRQ_STAT)) begin
				s_next.stat = s_reg.stat & ~wdata_i[1:0];
			end else if (hit(addr_i, `SMMA_OFF_IRQ_MASK)) begin
				s_next.mask = wdata_i[1:0];
			end
		end
		// pending loads from memory into the data register, single or cyclic
		if (s_reg.rd_pend) begin
			s_next.conn_mem_data_reg = cm_rdata_i;
			s_next.rd_pend = 1'b0;
			if (s_reg.st == SMMA_IDLE) begin
				s_next.stat[`SMMA_IRQ_DONE] = 1'b1;
			end
		end
		if (s_reg.dm_pend) begin
			s_next.conn_mem_data_reg = {s_reg.conn_mem_data_reg[15:8], dm_rdata_i};
			s_next.dm_pend = 1'b0;
			s_next.stat[`SMMA_IRQ_DONE] = 1'b1;
		end
		// cyclic sequencing
		case (s_reg.st)
			SMMA_IDLE: begin
			end
			SMMA_CYC_WR: begin
				s_next.cmw.we = 1'b1;
				s_next.cmw.addr = cur;
				s_next.cmw.data = wr_word;
				if (cur == s_reg.last) begin
					s_next.st = SMMA_IDLE;
					s_next.stat[`SMMA_IRQ_DONE] = 1'b1;
				end else begin
					s_next.dst = cur + 8'h01;
				end
			end
			SMMA_CYC_RD: begin
				// processor read of the data register advances the run
				if (rd_i && hit(addr_i, `SMMA_OFF_CONN_MEM_DATA_REG)) begin
					if (cur == s_reg.last) begin
						s_next.st = SMMA_IDLE;
						s_next.stat[`SMMA_IRQ_DONE] = 1'b1;
					end else begin
						s_next.dst = cur + 8'h01;
						s_next.rd_pend = 1'b1;
					end
				end
			end
			default: begin
				s_next.st = SMMA_IDLE;
			end
		endcase
		// register reads
		if (rd_i) begin
			if (hit(addr_i, `SMMA_OFF_CONN_MEM_DATA_REG)) begin
				s_next.rdata = s_reg.conn_mem_data_reg;
			end else if (hit(addr_i, `SMMA_OFF_CONN_MEM_ADDRESS_REG)) begin
				s_next.rdata = {2'b00, s_reg.mode.idc, s_reg.mode.lim, s_reg.mode.full, 1'b0,
					s_reg.mode.sel, s_reg.mode.rd, s_reg.dst};
			end else if (hit(addr_i, `SMMA_OFF_SFC)) begin
				s_next.rdata = s_reg.sfc;
				s_next.sfc = `SMMA_SFC_RST;
			end else if (hit(addr_i, `SMMA_OFF_IRQ_STAT)) begin
				s_next.rdata = {14'h0000, s_reg.stat};
			end else if (hit(addr_i, `SMMA_OFF_IRQ_MASK)) begin
				s_next.rdata = {14'h0000, s_reg.mask};
			end
		end
		// fault counting; a count in the read cycle wins over the clear
		if (prs_err_i && prs_en_i && prs_lock_i) begin
			if (s_reg.sfc != `SMMA_SFC_MAX) begin
				s_next.sfc = (rd_i && hit(addr_i, `SMMA_OFF_SFC)) ?
					16'h0001 : s_reg.sfc + 16'h0001;
				if (s_reg.sfc == `SMMA_SFC_MAX - 16'h0001) begin
					s_next.stat[`SMMA_IRQ_SAT] = 1'b1;
				end
			end else if (rd_i && hit(addr_i, `SMMA_OFF_SFC)) begin
				s_next.sfc = 16'h0001;
			end
		end
		// events set after clears so the set wins
		if (wr_i && hit(addr_i, `SMMA_OFF_IRQ_STAT)) begin
			s_next.stat = s_next.stat | (s_reg.stat & ~wdata_i[1:0] & 2'b00);
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '0;
			s_reg.st <= SMMA_IDLE;
			s_reg.dst <= `SMMA_DST_RST;
			// full cyclic bit set after reset; no access runs until a write
			s_reg.mode <= `SMMA_MODE_RST;
			s_reg.conn_mem_data_reg <= `SMMA_CONN_MEM_DATA_REG_RST;
			s_reg.sfc <= `SMMA_SFC_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_o = s_reg.rdata;
	assign cm_we_o = s_reg.cmw.we;
	assign cm_wdata_o = s_reg.cmw.data;
	assign cm_addr_o = s_reg.rd_pend ? cur : s_reg.cmw.addr;
	assign dm_addr_o = s_reg.dst;
	assign irq_o = |(s_reg.stat & s_reg.mask);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// processor read of the fault counter
	sequence sfc_read_s;
		rd_i && hit(addr_i, `SMMA_OFF_SFC);
	endsequence
	// qualified sequence error from the analyser
	sequence sfc_event_s;
		prs_err_i && prs_en_i && prs_lock_i;
	endsequence
	// cyclic write on its final location, with no new launch beside it
	sequence cyc_wr_last_s;
		s_reg.st == SMMA_CYC_WR && cur == s_reg.last && !wr_i;
	endsequence
	// processor read that steps a cyclic read run
	sequence cyc_rd_step_s;
		s_reg.st == SMMA_CYC_RD && rd_i && hit(addr_i, `SMMA_OFF_CONN_MEM_DATA_REG) && !wr_i;
	endsequence
	// read data only stand in the cycle after a read strobe
	rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data present without a read");
	// a connection memory write only ever comes from a select of it
	we_sel_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cm_we_o |-> s_reg.mode.sel)
		else $error("write pulse with data memory selected");
	// a write pulse never belongs to a read request
	we_rdbit_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cm_we_o |-> !s_reg.mode.rd)
		else $error("write pulse during a read request");
	// a cyclic read run never writes the memory
	cyc_rd_nowe_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.st == SMMA_CYC_RD |-> !cm_we_o)
		else $error("write pulse during cyclic read");
	// a write run stops once its last location has gone out
	cyc_wr_end_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cyc_wr_last_s |=> s_reg.st == SMMA_IDLE && s_reg.stat[`SMMA_IRQ_DONE])
		else $error("cyclic write did not end");
	// each processor read of a read run short of its last location moves on and reloads
	cyc_rd_adv_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cyc_rd_step_s and (cur != s_reg.last) |=> s_reg.dst == $past(cur) + 8'h01 && s_reg.rd_pend)
		else $error("cyclic read did not advance");
	// a pending load takes the connection memory word
	rd_load_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.rd_pend |=> s_reg.conn_mem_data_reg == $past(cm_rdata_i))
		else $error("connection memory word not loaded");
	// a single read raises the done flag as it lands
	single_rd_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.rd_pend && s_reg.st == SMMA_IDLE |=> s_reg.stat[`SMMA_IRQ_DONE])
		else $error("single read not flagged done");
	// a qualified error below the top, outside a counter read, adds exactly one
	sfc_count_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		sfc_event_s and !(rd_i && hit(addr_i, `SMMA_OFF_SFC)) and (s_reg.sfc != `SMMA_SFC_MAX)
		|=> s_reg.sfc == $past(s_reg.sfc) + 16'h0001)
		else $error("fault not counted");
	// reaching the top raises the saturation flag
	sfc_satflag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		sfc_event_s and (s_reg.sfc == `SMMA_SFC_MAX - 16'h0001) |=> s_reg.stat[`SMMA_IRQ_SAT])
		else $error("saturation not flagged");
	// a full write run always ends on the last location overall
	last_full_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.st == SMMA_CYC_WR && !s_reg.mode.lim |-> s_reg.last == `SMMA_LAST_LOC)
		else $error("full run has a wrong end");
	// with no run and no register write the address stands still
	dst_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.st == SMMA_IDLE && !wr_i |=> $stable(s_reg.dst))
		else $error("destination moved while idle");
	// interrupt follows an unmasked done flag
	irq_follow_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.stat[`SMMA_IRQ_DONE] && s_reg.mask[`SMMA_IRQ_DONE] |-> irq_o)
		else $error("interrupt missing for done flag");
	sfc_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		sfc_read_s and !(prs_err_i && prs_en_i && prs_lock_i) |=> s_reg.sfc == 16'h0000)
		else $error("fault counter not cleared by read");
	sfc_sat_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.sfc == `SMMA_SFC_MAX && !(rd_i && hit(addr_i, `SMMA_OFF_SFC))
		|=> s_reg.sfc == `SMMA_SFC_MAX)
		else $error("fault counter wrapped");
	sfc_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!(prs_en_i && prs_lock_i) && !(rd_i && hit(addr_i, `SMMA_OFF_SFC))
		|=> $stable(s_reg.sfc))
		else $error("fault counted while analyser idle");
	dm_nowrite_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_i && hit(addr_i, `SMMA_OFF_CONN_MEM_ADDRESS_REG) && !wdata_i[8 + `SMMA_AM_SEL]
		|=> !cm_we_o)
		else $error("write issued for data memory request");
	single_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		wr_i && hit(addr_i, `SMMA_OFF_CONN_MEM_ADDRESS_REG) && wdata_i[15:8] == 8'h02
		|=> cm_we_o && cm_addr_o == $past(wdata_i[7:0]))
		else $error("single write not launched");
	idc_map_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cm_we_o && s_reg.mode.idc |-> cm_wdata_o[7:0] == cm_addr_o)
		else $error("identity connection source mismatch");
	cyc_step_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.st == SMMA_CYC_WR && cur != s_reg.last |=> s_reg.dst == $past(cur) + 8'h01)
		else $error("cyclic address did not advance");
	lim_end_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.st == SMMA_CYC_WR && s_reg.mode.lim |-> cur[7:5] == s_reg.last[7:5])
		else $error("limited run left its multiplex");
	dm_byte_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		s_reg.dm_pend |=> s_reg.conn_mem_data_reg[7:0] == $past(dm_rdata_i))
		else $error("data memory byte not returned");
endmodule // smma_core

// *** smma_core_bench.sv ***
// self-checking bench for the switch matrix memory access block
`timescale 1ns/1ps
`include "smma_params.svh"
module smma_core_bench;
	// ----------------------------------------
	// signals and memory stand-ins
	// ----------------------------------------
	logic clk_sys_i = 1'b0; // 250 MHz system clock
	logic srst_i = 1'b1; // sync reset
	logic [7:0] addr_i = 8'h00; // register address
	logic [15:0] wdata_i = 16'h0000; // write data
	logic wr_i = 1'b0; // write strobe
	logic rd_i = 1'b0; // read strobe
	logic prs_err_i = 1'b0; // analyser error pulse
	logic prs_en_i = 1'b0; // analyser enabled
	logic prs_lock_i = 1'b0; // analyser locked
	wire [15:0] rdata_o, cm_wdata_o;
	wire [7:0] cm_addr_o, dm_addr_o;
	wire cm_we_o, irq_o;
	// memory contents derived from the address, so every location differs
	wire [15:0] cm_rdata_i = {8'hA5, cm_addr_o};
	wire [7:0] dm_rdata_i = ~dm_addr_o;
	int errors = 0;
	int comparisons = 0;
	logic [15:0] rv;
	smma_core u_smma_core (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cm_addr_o(cm_addr_o),
		.cm_wdata_o(cm_wdata_o), .cm_we_o(cm_we_o), .cm_rdata_i(cm_rdata_i),
		.dm_addr_o(dm_addr_o), .dm_rdata_i(dm_rdata_i), .prs_err_i(prs_err_i),
		.prs_en_i(prs_en_i), .prs_lock_i(prs_lock_i), .irq_o(irq_o));
	always #2 clk_sys_i = ~clk_sys_i;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// counts write pulses over a fixed span, so strays are caught too
	task watch_we(input logic [7:0] first, input int n, input logic [15:0] d, input bit idc);
		int seen;
		seen = 0;
		for (int i = 0; i < 300; i++) begin
			#1;
			if (cm_we_o === 1'b1) begin
				check({8'h00, cm_addr_o}, {8'h00, first + 8'(seen)});
				check(cm_wdata_o, idc ? {d[15:8], first + 8'(seen)} : d);
				seen++;
			end
			@(posedge clk_sys_i);
		end
		check(16'(seen), 16'(n));
	endtask
	task irq_is(input logic v);
		repeat (2) @(posedge clk_sys_i);
		#1 check({15'h0, irq_o}, {15'h0, v});
	endtask
	task errs(input logic en, input logic lock, input int n);
		@(posedge clk_sys_i);
		prs_en_i <= en;
		prs_lock_i <= lock;
		prs_err_i <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		prs_err_i <= 1'b0;
	endtask
	// cyclic read: each processor read reloads the next location
	task cyc_read(input logic [15:0] mode, input int n);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, mode);
		repeat (3) @(posedge clk_sys_i);
		for (int k = 0; k < n; k++) begin
			rd(`SMMA_OFF_CONN_MEM_DATA_REG, rv);
			check(rv, {8'hA5, mode[7:0] + 8'(k)});
			repeat (3) @(posedge clk_sys_i);
		end
		watch_we(8'h00, 0, 16'h0000, 1'b0);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(`SMMA_OFF_CONN_MEM_ADDRESS_REG, rv);
		check(rv, `SMMA_CONN_MEM_ADDRESS_REG_RST);
		rd(`SMMA_OFF_CONN_MEM_DATA_REG, rv);
		check(rv, `SMMA_CONN_MEM_DATA_REG_RST);
		rd(`SMMA_OFF_SFC, rv);
		check(rv, `SMMA_SFC_RST);
		rd(8'h30, rv);
		check(rv, 16'h0000);
		$display("test reset end");
	endtask
	task t_single;
		wr(`SMMA_OFF_CONN_MEM_DATA_REG, 16'h1234);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h0243);
		watch_we(8'h43, 1, 16'h1234, 1'b0);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h2243);
		watch_we(8'h43, 1, 16'h1234, 1'b1);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h0343);
		repeat (3) @(posedge clk_sys_i);
		rd(`SMMA_OFF_CONN_MEM_DATA_REG, rv);
		check(rv, 16'hA543);
		$display("test single end");
	endtask
	task t_data_mem;
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h0055);
		watch_we(8'h00, 0, 16'h0000, 1'b0);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h0177);
		repeat (3) @(posedge clk_sys_i);
		rd(`SMMA_OFF_CONN_MEM_DATA_REG, rv);
		check({8'h00, rv[7:0]}, 16'h0088);
		$display("test data memory end");
	endtask
	task t_cyclic;
		wr(`SMMA_OFF_CONN_MEM_DATA_REG, 16'hBEEF);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h125C);
		watch_we(8'h5C, 4, 16'hBEEF, 1'b0);
		irq_is(1'b0);
		wr(`SMMA_OFF_IRQ_MASK, 16'h0001);
		irq_is(1'b1);
		rd(`SMMA_OFF_IRQ_STAT, rv);
		check(rv, 16'h0001);
		wr(`SMMA_OFF_IRQ_STAT, 16'h0001);
		irq_is(1'b0);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h325C);
		watch_we(8'h5C, 4, 16'hBEEF, 1'b1);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h0AFC);
		watch_we(8'hFC, 4, 16'hBEEF, 1'b0);
		wr(`SMMA_OFF_CONN_MEM_ADDRESS_REG, 16'h2AFD);
		watch_we(8'hFD, 3, 16'hBEEF, 1'b1);
		cyc_read(16'h0BFD, 3);
		cyc_read(16'h135E, 2);
		$display("test cyclic end");
	endtask
	task t_count;
		errs(1'b0, 1'b1, 4);
		errs(1'b1, 1'b0, 4);
		errs(1'b1, 1'b1, 3);
		rd(`SMMA_OFF_SFC, rv);
		check(rv, 16'h0003);
		wr(`SMMA_OFF_SFC, 16'h1234);
		rd(`SMMA_OFF_SFC, rv);
		check(rv, 16'h0000);
		errs(1'b1, 1'b1, 65540);
		rd(`SMMA_OFF_SFC, rv);
		check(rv, `SMMA_SFC_MAX);
		rd(`SMMA_OFF_IRQ_STAT, rv);
		check(rv & 16'h0002, 16'h0002);
		$display("test counter end");
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		t_reset();
		t_single();
		t_data_mem();
		t_cyclic();
		t_count();
		give_verdict();
	end
	// a hang counts as a mismatch
	initial begin
		#400000;
		errors++;
		give_verdict();
	end
endmodule // smma_core_bench
